// [filter_link_if.sv]
// Carrier between the sequencer and a persistence filter.
`timescale 1ns/1ps
interface filter_link_if;
    logic level;
    logic qualified;
    modport filter (input level, output qualified);
    modport user (output level, input qualified);
endinterface : filter_link_if

// [persist_filter.sv]
// Qualifies a level only after it has persisted for a minimum number of cycles.
`timescale 1ns/1ps
module persist_filter #(
    parameter int MIN_CYCLES = 25,
    parameter int CNT_W      = 12
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    filter_link_if.filter      link
);
    logic [CNT_W-1:0] count;

    // The count saturates, so a long condition never wraps and drops out.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!link.level) begin
            count <= '0;
        end else if (count != CNT_W'(MIN_CYCLES)) begin
            count <= count + 1'b1;
        end
    end

    // The level must still be present when the count is reached.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            link.qualified <= 1'b0;
        end else begin
            link.qualified <= link.level && (count == CNT_W'(MIN_CYCLES));
        end
    end

    AST_FILTER_DROP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !link.level |=> !link.qualified)
        else $error("Qualified output stayed up after the level dropped.");

    AST_FILTER_SHORT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(link.level) ##1 !link.level |-> ##1 !link.qualified)
        else $error("A one-cycle level was qualified.");
endmodule : persist_filter

// [reset_seq_pkg.sv]
// Shared constants and types for the reset source sequencer.
package reset_seq_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint PS_PER_NS = 1000;
    localparam longint PS_PER_US = 1000000;
    // Minimum low time on the reset pin that counts as a reset, in ns.
    localparam int PIN_MIN_PULSE_NS = 100;
    localparam int PIN_MIN_CYCLES =
        int'((PIN_MIN_PULSE_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // Minimum time the supply must stay below the brown-out level, in us.
    localparam int BROWNOUT_MIN_US = 2;
    localparam int BROWNOUT_MIN_CYCLES =
        int'((BROWNOUT_MIN_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int FILTER_CNT_W = 12;
    // Reset stretch times per clock select fuse setting, in us.
    localparam int STRETCH_SHORT_US = 4;
    localparam int STRETCH_MID_US = 4100;
    localparam int STRETCH_LONG_US = 65000;
    localparam int STRETCH_W = 24;
    localparam int STRETCH_SHORT_CYCLES =
        int'((STRETCH_SHORT_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int STRETCH_MID_CYCLES =
        int'((STRETCH_MID_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int STRETCH_LONG_CYCLES =
        int'((STRETCH_LONG_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [STRETCH_W-1:0] STRETCH_NONE = 24'h000001;
    // Clock select fuse encodings.
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_SHORT = 2'h1;
    localparam logic [1:0] SEL_MID = 2'h2;
    // Reset cause flag positions.
    localparam int FLAG_COUNT = 5;
    localparam int FLAG_POWER_ON = 0;
    localparam int FLAG_PIN = 1;
    localparam int FLAG_BROWNOUT = 2;
    localparam int FLAG_WATCHDOG = 3;
    localparam int FLAG_TEST_PORT = 4;
    localparam logic [FLAG_COUNT-1:0] CAUSE_RESET_VALUE = 5'h00;
    localparam logic [FLAG_COUNT-1:0] POWER_ON_MASK = 5'h01;
    typedef enum logic [1:0] {SEQ_HOLD, SEQ_STRETCH, SEQ_RUN} seq_state_type;
endpackage : reset_seq_pkg

// [reset_source_sequencer.sv]
// Reset source sequencer: five reset sources merged into one stretched internal reset.
`timescale 1ns/1ps
module reset_source_sequencer #(
    parameter int STRETCH_MID_CYCLES  = reset_seq_pkg::STRETCH_MID_CYCLES,
    parameter int STRETCH_LONG_CYCLES = reset_seq_pkg::STRETCH_LONG_CYCLES
) (
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    input  wire logic                                supplyBelowPowerOn,
    input  wire logic                                resetPin_n,
    input  wire logic                                watchdogExpired,
    input  wire logic                                watchdogEnabled,
    input  wire logic                                brownoutBelowLow,
    input  wire logic                                brownoutBelowHigh,
    input  wire logic                                brownoutEnableFuse,
    input  wire logic                                brownoutLevelFuse,
    input  wire logic                                testPortResetBit,
    input  wire logic [1:0]                          clockSelectFuses,
    input  wire logic                                causeWrite,
    input  wire logic [reset_seq_pkg::FLAG_COUNT-1:0] causeWriteData,
    output logic                                     internalReset,
    output logic                                     ioPortReset,
    output logic                                     fetchResetVector,
    output logic                                     watchdogResetPulse,
    output logic [reset_seq_pkg::FLAG_COUNT-1:0]     resetCause
);
    localparam int SW = reset_seq_pkg::STRETCH_W;
    localparam logic [SW-1:0] STRETCH_NONE_VAL = reset_seq_pkg::STRETCH_NONE;

    function automatic logic [SW-1:0] stretchFor(input logic [1:0] sel);
        logic [SW-1:0] length;
        length = SW'(STRETCH_LONG_CYCLES);
        if (sel == reset_seq_pkg::SEL_NONE) begin
            length = reset_seq_pkg::STRETCH_NONE;
        end else if (sel == reset_seq_pkg::SEL_SHORT) begin
            length = SW'(reset_seq_pkg::STRETCH_SHORT_CYCLES);
        end else if (sel == reset_seq_pkg::SEL_MID) begin
            length = SW'(STRETCH_MID_CYCLES);
        end
        return length;
    endfunction : stretchFor

    logic                      brownoutRaw;
    logic                      rawAny;
    logic [3:0]                syncFirst;
    logic [3:0]                syncSecond;
    logic                      porSync;
    logic                      pinLowSync;
    logic                      brownoutSync;
    logic                      testSync;
    logic                      wdPulse;
    logic                      sourceActive;
    logic [SW-1:0]             stretchCount;
    logic [SW:0]               quietCycles;
    logic [reset_seq_pkg::FLAG_COUNT-1:0] setVec;
    logic [reset_seq_pkg::FLAG_COUNT-1:0] clearVec;
    reset_seq_pkg::seq_state_type state;
    reset_seq_pkg::seq_state_type next_state;

    filter_link_if pinLink ();
    filter_link_if brownoutLink ();

    // The level fuse picks the comparator before synchronising, so only one path is sampled.
    assign brownoutRaw = brownoutLevelFuse ? brownoutBelowHigh : brownoutBelowLow;

    // Raw sources for the clockless port reset; the watchdog pulse is already synchronous.
    assign rawAny = supplyBelowPowerOn | !resetPin_n | (brownoutEnableFuse & brownoutRaw)
                  | testPortResetBit | wdPulse;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            syncFirst  <= 4'hF;
            syncSecond <= 4'hF;
        end else begin
            syncFirst  <= {testPortResetBit, brownoutRaw, !resetPin_n, supplyBelowPowerOn};
            syncSecond <= syncFirst;
        end
    end

    assign porSync      = syncSecond[0];
    assign pinLowSync   = syncSecond[1];
    assign brownoutSync = syncSecond[2];
    assign testSync     = syncSecond[3];

    assign pinLink.level      = pinLowSync;
    assign brownoutLink.level = brownoutSync & brownoutEnableFuse;

    persist_filter #(
        .MIN_CYCLES (reset_seq_pkg::PIN_MIN_CYCLES),
        .CNT_W      (reset_seq_pkg::FILTER_CNT_W)
    ) pinFilter (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .link    (pinLink)
    );

    persist_filter #(
        .MIN_CYCLES (reset_seq_pkg::BROWNOUT_MIN_CYCLES),
        .CNT_W      (reset_seq_pkg::FILTER_CNT_W)
    ) brownoutFilter (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .link    (brownoutLink)
    );

    // One-cycle watchdog reset pulse; an expiry sampled while the pulse is high is masked and gives no second pulse.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wdPulse <= 1'b0;
        end else begin
            wdPulse <= watchdogExpired & watchdogEnabled & !wdPulse;
        end
    end

    assign watchdogResetPulse = wdPulse;

    assign sourceActive = porSync | pinLink.qualified | brownoutLink.qualified
                        | testSync | wdPulse;

    always_comb begin
        next_state = state;
        case (state)
            reset_seq_pkg::SEQ_HOLD: begin
                if (!sourceActive) begin
                    next_state = reset_seq_pkg::SEQ_STRETCH;
                end
            end
            reset_seq_pkg::SEQ_STRETCH: begin
                if (sourceActive) begin
                    next_state = reset_seq_pkg::SEQ_HOLD;
                end else if (stretchCount == STRETCH_NONE_VAL) begin
                    next_state = reset_seq_pkg::SEQ_RUN;
                end
            end
            default: begin
                if (sourceActive) begin
                    next_state = reset_seq_pkg::SEQ_HOLD;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= reset_seq_pkg::SEQ_HOLD;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stretchCount <= STRETCH_NONE_VAL;
        end else if (state != reset_seq_pkg::SEQ_STRETCH) begin
            stretchCount <= stretchFor(clockSelectFuses);
        end else begin
            stretchCount <= stretchCount - 1'b1;
        end
    end

    // Release happens only on a clock edge; ioPortReset follows internalReset and clears one edge later.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            internalReset    <= 1'b1;
            fetchResetVector <= 1'b0;
        end else begin
            internalReset    <= next_state != reset_seq_pkg::SEQ_RUN;
            fetchResetVector <= internalReset && next_state == reset_seq_pkg::SEQ_RUN;
        end
    end

    // Asserts with no clock; clears only when the clocked internal reset has released.
    always_ff @(posedge ref_clk or posedge rawAny) begin
        if (rawAny) begin
            ioPortReset <= 1'b1;
        end else if (!rst_n) begin
            ioPortReset <= 1'b1;
        end else begin
            ioPortReset <= internalReset;
        end
    end

    always_comb begin
        setVec = '0;
        setVec[reset_seq_pkg::FLAG_POWER_ON]  = porSync;
        setVec[reset_seq_pkg::FLAG_PIN]       = pinLink.qualified;
        setVec[reset_seq_pkg::FLAG_BROWNOUT]  = brownoutLink.qualified;
        setVec[reset_seq_pkg::FLAG_WATCHDOG]  = wdPulse;
        setVec[reset_seq_pkg::FLAG_TEST_PORT] = testSync;
        clearVec = causeWrite ? ~causeWriteData : '0;
        if (porSync) begin
            clearVec = clearVec | ~reset_seq_pkg::POWER_ON_MASK;
        end
    end

    // A new cause in the same cycle as its clear is kept.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resetCause <= reset_seq_pkg::CAUSE_RESET_VALUE;
        end else begin
            resetCause <= (resetCause & ~clearVec) | setVec;
        end
    end

    // Helper for checking: cycles since all sources went quiet.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sourceActive) begin
            quietCycles <= '0;
        end else if (quietCycles != {(SW+1){1'b1}}) begin
            quietCycles <= quietCycles + 1'b1;
        end
    end

    AST_HOLD_WHILE_SOURCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sourceActive |=> internalReset && state == reset_seq_pkg::SEQ_HOLD)
        else $error("Internal reset not held while a source is active.");

    AST_TEST_PORT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        testSync [*2] |=> internalReset)
        else $error("Test port reset bit did not hold the device in reset.");

    AST_IO_ASYNC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rawAny |=> ioPortReset)
        else $error("Port reset not asserted for an active source.");

    AST_STRETCH_LENGTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(internalReset) && $stable(clockSelectFuses)
            |-> quietCycles == {1'b0, stretchFor(clockSelectFuses)} + 1'b1)
        else $error("Internal reset released after the wrong stretch.");

    AST_FETCH_ON_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(internalReset) |-> fetchResetVector ##1 !fetchResetVector)
        else $error("Reset vector fetch not a single pulse at release.");

    AST_WD_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdPulse |=> !wdPulse ##0 internalReset)
        else $error("Watchdog reset pulse longer than one cycle.");

    AST_WD_ENABLED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdPulse |-> $past(watchdogEnabled) && $past(watchdogExpired))
        else $error("Watchdog reset without an enabled expiry.");

    AST_CAUSE_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdPulse |=> resetCause[reset_seq_pkg::FLAG_WATCHDOG])
        else $error("Watchdog cause flag not set.");

    AST_POR_KEEPS_OWN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        porSync && !pinLink.qualified && !brownoutLink.qualified && !testSync && !wdPulse
            |=> resetCause == reset_seq_pkg::POWER_ON_MASK)
        else $error("Power-on did not leave only its own cause flag.");
endmodule : reset_source_sequencer

// [reset_source_sequencer_test.sv]
// Self-checking testbench for the reset source sequencer.
`timescale 1ns/1ps
module reset_source_sequencer_test;
    localparam int MID  = 20;
    localparam int LONG = 40;
    logic       ref_clk            = 1'b0;
    logic       rst_n              = 1'b0;
    logic       watchdogEnabled    = 1'b1;
    logic       brownoutEnableFuse = 1'b1;
    logic       brownoutLevelFuse  = 1'b0;
    logic [1:0] clockSelectFuses   = 2'h2;
    logic       causeWrite         = 1'b0;
    logic [4:0] causeWriteData     = 5'h1F;
    logic       supplyBelowPowerOn, resetPin_n, watchdogExpired;
    logic       brownoutBelowLow, brownoutBelowHigh, testPortResetBit;
    logic       internalReset, ioPortReset, fetchResetVector, watchdogResetPulse;
    logic [4:0] resetCause;
    int         errors     = 0;
    int         checksDone = 0;

    source_model src (.ref_clk(ref_clk), .supplyBelowPowerOn(supplyBelowPowerOn),
        .resetPin_n(resetPin_n), .watchdogExpired(watchdogExpired),
        .brownoutBelowLow(brownoutBelowLow), .brownoutBelowHigh(brownoutBelowHigh),
        .testPortResetBit(testPortResetBit));

    // Short stretch values keep the run brief; expectations use the same values.
    reset_source_sequencer #(.STRETCH_MID_CYCLES(MID), .STRETCH_LONG_CYCLES(LONG)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .supplyBelowPowerOn(supplyBelowPowerOn),
        .resetPin_n(resetPin_n), .watchdogExpired(watchdogExpired),
        .watchdogEnabled(watchdogEnabled), .brownoutBelowLow(brownoutBelowLow),
        .brownoutBelowHigh(brownoutBelowHigh), .brownoutEnableFuse(brownoutEnableFuse),
        .brownoutLevelFuse(brownoutLevelFuse), .testPortResetBit(testPortResetBit),
        .clockSelectFuses(clockSelectFuses), .causeWrite(causeWrite),
        .causeWriteData(causeWriteData), .internalReset(internalReset),
        .ioPortReset(ioPortReset), .fetchResetVector(fetchResetVector),
        .watchdogResetPulse(watchdogResetPulse), .resetCause(resetCause));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic stay(input logic val, input int n);
        repeat (n) begin
            tick(1);
            check(internalReset, val);
        end
    endtask : stay

    // A window is allowed because the asynchronous sources pass a synchroniser first.
    task automatic release_in(input int lo, input int hi);
        int n;
        n = 0;
        while (internalReset === 1'b1 && n <= hi) begin
            tick(1);
            n++;
        end
        check(10'((n >= lo && n <= hi) ? lo : n), 10'(lo));
        check(fetchResetVector, 1'b1);
        tick(1);
        check({fetchResetVector, ioPortReset}, 2'b00);
    endtask : release_in

    task automatic write_cause(input logic [4:0] d, input logic [4:0] exp);
        causeWrite = 1'b1;
        causeWriteData = d;
        tick(1);
        causeWrite = 1'b0;
        check(resetCause, exp);
    endtask : write_cause

    task automatic t_power_up();
        tick(4);
        check({internalReset, ioPortReset}, 2'b11);
        rst_n = 1'b1;
        release_in(MID, MID + 4);
        check(resetCause, 5'h11);
        write_cause(5'h00, 5'h00);
    endtask : t_power_up

    task automatic t_watchdog_stretch();
        int len [4] = '{1, 1000, MID, LONG};
        for (int s = 0; s < 4; s++) begin
            clockSelectFuses = 2'(s);
            src.hold(5, 1);
            check(watchdogResetPulse, 1'b1);
            tick(1);
            check({watchdogResetPulse, internalReset}, 2'b01);
            release_in(len[s], len[s] + 1);
            check(resetCause, 5'h08);
            write_cause(5'h17, 5'h00);
        end
        clockSelectFuses = 2'h2;
    endtask : t_watchdog_stretch

    task automatic t_watchdog_off();
        watchdogEnabled = 1'b0;
        src.hold(5, 1);
        check(watchdogResetPulse, 1'b0);
        stay(1'b0, 5);
        watchdogEnabled = 1'b1;
    endtask : t_watchdog_off

    task automatic t_pin();
        src.drive(1, 1'b1);
        #1;
        check(ioPortReset, 1'b1);
        stay(1'b0, 10);
        src.drive(1, 1'b0);
        stay(1'b0, 4);
        src.hold(1, 1);
        stay(1'b0, 4);
        src.hold(1, 40);
        release_in(MID, MID + 6);
        check(resetCause, 5'h02);
        write_cause(5'h1D, 5'h00);
    endtask : t_pin

    task automatic t_brownout();
        brownoutEnableFuse = 1'b0;
        src.hold(2, 520);
        check(internalReset, 1'b0);
        brownoutEnableFuse = 1'b1;
        src.hold(3, 520);
        check(internalReset, 1'b0);
        src.hold(2, 100);
        check(internalReset, 1'b0);
        src.hold(2, 520);
        check(internalReset, 1'b1);
        release_in(MID, MID + 6);
        check(resetCause, 5'h04);
        write_cause(5'h1B, 5'h00);
        brownoutLevelFuse = 1'b1;
        src.hold(3, 520);
        check(internalReset, 1'b1);
        release_in(MID, MID + 6);
        write_cause(5'h1B, 5'h00);
        brownoutLevelFuse = 1'b0;
    endtask : t_brownout

    task automatic t_test_port();
        src.drive(4, 1'b1);
        tick(4);
        stay(1'b1, 50);
        src.drive(4, 1'b0);
        release_in(MID, MID + 5);
        check(resetCause, 5'h10);
        write_cause(5'h0F, 5'h00);
    endtask : t_test_port

    // Power-on during a watchdog stretch also proves that it wipes the other flags.
    task automatic t_power_on();
        src.hold(5, 1);
        src.drive(0, 1'b1);
        tick(4);
        check(internalReset, 1'b1);
        check(resetCause, 5'h01);
        src.drive(0, 1'b0);
        release_in(MID, MID + 5);
        write_cause(5'h1E, 5'h00);
    endtask : t_power_on

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        t_power_up();
        t_watchdog_stretch();
        t_watchdog_off();
        t_pin();
        t_brownout();
        t_test_port();
        t_power_on();
        give_verdict();
    end

    // The tests need well under ten thousand cycles, so this limit only cuts a hang.
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule : reset_source_sequencer_test

// [source_model.sv]
// Behavioural model of the supply monitors, reset pin, watchdog and test port.
`timescale 1ns/1ps
module source_model (
    input  wire logic ref_clk,
    output logic      supplyBelowPowerOn,
    output logic      resetPin_n,
    output logic      watchdogExpired,
    output logic      brownoutBelowLow,
    output logic      brownoutBelowHigh,
    output logic      testPortResetBit
);
    // Index 0 power, 1 pin, 2 low comparator, 3 high comparator, 4 test port, 5 watchdog.
    logic [5:0] active = 6'h00;

    // The pin is the only source that is active low.
    assign supplyBelowPowerOn = active[0];
    assign resetPin_n         = ~active[1];
    assign brownoutBelowLow   = active[2];
    assign brownoutBelowHigh  = active[3];
    assign testPortResetBit   = active[4];
    assign watchdogExpired    = active[5];

    // Levels move just after an edge so that no sampling edge sees them change.
    task automatic drive(input int which, input logic val);
        @(posedge ref_clk);
        #1;
        active[which] = val;
    endtask : drive

    // Holds a source active for exactly the given number of sampling edges.
    task automatic hold(input int which, input int cycles);
        drive(which, 1'b1);
        repeat (cycles - 1) @(posedge ref_clk);
        drive(which, 1'b0);
    endtask : hold
endmodule : source_model
